// ---- rtl/arith_pkg.sv ----
// Overview of operation
// - Byte registers hold operands, then results
// - Operation chosen by register write order
// - Write to register 0 restarts, arms monitor
// - Orders 012345, 0145, 0415 pick operations
// - Quotient/product low, remainder in registers 4-5
// - Write to register 5 starts mul/div
// - No busy flag; fixed time; results held
// - Any register 0 write starts anew
// - Shift: write 0..3, then control starts
// - Control write launches shift/normalize, except count zero with top bit set
// - Control at 0xEF: err, ovf, dir, count
// - Retrigger before completion sets error flag
// - Reading control clears error flag
// - Overflow on divide by zero, big product
// - Direction bit one shifts right
// - Count zero normalizes, else shifts count
// - Normalize shifts left until top bit set
// - Normalize leaves shift total in count
// - Nonzero normalize max 31 shifts, six cycles
// - Divide 32/16 six cycles, others four
// - Zero fill; four shifts then six
// - Normalize with top bit set flags overflow
// - Reading registers 0-3 during shift sets error flag
package arith_pkg;

    // Register addresses in the special function space
    localparam logic [7:0] ADDR_REG0    = 8'hE9;
    localparam logic [7:0] ADDR_REG1    = 8'hEA;
    localparam logic [7:0] ADDR_REG2    = 8'hEB;
    localparam logic [7:0] ADDR_REG3    = 8'hEC;
    localparam logic [7:0] ADDR_REG4    = 8'hED;
    localparam logic [7:0] ADDR_REG5    = 8'hEE;
    localparam logic [7:0] ADDR_CONTROL = 8'hEF;

    // Control register fields
    localparam int BIT_ERR = 7;
    localparam int BIT_OVF = 6;
    localparam int BIT_DIR = 5;
    localparam logic [7:0] CONTROL_RESET = 8'h00;

    // Execution times in machine cycles, then shift amounts in bits per cycle
    localparam logic [2:0] CYC_DIV32 = 3'h6;
    localparam logic [2:0] CYC_DIV16 = 3'h4;
    localparam logic [2:0] CYC_MUL   = 3'h4;
    localparam logic [4:0] SHIFT_FIRST = 5'h04;
    localparam logic [4:0] SHIFT_NEXT  = 5'h06;

    // Operation being computed or read out
    typedef enum logic [2:0] {
        OP_NONE  = 3'b000,
        OP_DIV32 = 3'b001,
        OP_DIV16 = 3'b011,
        OP_MUL   = 3'b010,
        OP_SHIFT = 3'b110
    } op_t;

    // Write-order tracker, Gray along the 32/16 path
    typedef enum logic [2:0] {
        WS_IDLE = 3'b000,
        WS_W0   = 3'b001,
        WS_W1   = 3'b011,
        WS_W2   = 3'b010,
        WS_W3   = 3'b110,
        WS_W4   = 3'b111,
        WS_W04  = 3'b101,
        WS_W041 = 3'b100
    } wseq_t;

endpackage

// ---- rtl/arith_unit.sv ----
`timescale 1ns/100ps
`default_nettype none
module arith_unit
    import arith_pkg::*;
(
    // Clock and reset
    input  wire logic       mclk,
    input  wire logic       rst,
    // Special function register port
    input  wire logic [7:0] sfr_addr,
    input  wire logic       sfr_wr,
    input  wire logic       sfr_rd,
    input  wire logic [7:0] sfr_wdata,
    output logic      [7:0] sfr_rdata,
    output logic            sfr_sel
);

    logic [7:0]  md_q [6];
    logic [7:0]  md_d [6];
    logic        err_q, err_d, ovf_q, ovf_d, dir_q, dir_d;
    logic [4:0]  cnt_q, cnt_d;
    wseq_t       ws_q, ws_d;
    op_t         op_q, op_d;
    logic        busy_q, busy_d;
    logic        mon_q, mon_d;
    logic [2:0]  cyc_q, cyc_d;
    logic        norm_q, norm_d;
    logic [4:0]  left_q, left_d;
    logic        first_q, first_d;
    // Set once registers 2 and 3 arrive in order; tells 32/16 from 16/16 at the last write
    logic        div32_q, div32_d;

    logic [31:0] op32, quo32, prod;
    logic [15:0] dvsr, rem16;
    logic [31:0] shv;
    logic [4:0]  step, lz;
    logic        wr_md [6];
    logic        rd_md [6];
    logic        wr_ctl, rd_ctl;

    // Per-register strobes
    genvar g;
    generate
        for (g = 0; g < 6; g++)
        begin : g_strobe
            assign wr_md[g] = sfr_wr && (sfr_addr == ADDR_REG0 + 8'(g));
            assign rd_md[g] = sfr_rd && (sfr_addr == ADDR_REG0 + 8'(g));
        end
    endgenerate
    assign wr_ctl = sfr_wr && (sfr_addr == ADDR_CONTROL);
    assign rd_ctl = sfr_rd && (sfr_addr == ADDR_CONTROL);

    // Division sources by mode; 16/16 uses only registers 0,1 as dividend
    assign op32  = (op_q == OP_DIV16) ? {16'h0000, md_q[1], md_q[0]}
                                      : {md_q[3], md_q[2], md_q[1], md_q[0]};
    assign dvsr  = {md_q[5], md_q[4]};
    assign quo32 = (dvsr == 16'h0000) ? 32'hFFFFFFFF : op32 / {16'h0000, dvsr};
    assign rem16 = (dvsr == 16'h0000) ? 16'hFFFF : 16'(op32 % {16'h0000, dvsr});
    assign prod  = {md_q[1], md_q[0]} * {md_q[5], md_q[4]};

    // Leading zero count for normalize, at most 31
    always_comb
    begin
        lz = 5'h1F;
        for (int i = 0; i < 32; i++)
        begin
            if (shv[i])
            begin
                lz = 5'(31 - i);
            end
        end
    end

    assign shv  = {md_q[3], md_q[2], md_q[1], md_q[0]};

    // Shift amount for this cycle: four first, then six
    always_comb
    begin
        step = first_q ? SHIFT_FIRST : SHIFT_NEXT;
        if (norm_q)
        begin
            if (lz < step)
            begin
                step = lz;
            end
        end
        else if (left_q < step)
        begin
            step = left_q;
        end
    end

    // Register read mux; reads also clear or set the error flag besides monitoring
    always_comb
    begin
        sfr_sel   = 1'b0;
        sfr_rdata = 8'h00;
        for (int i = 0; i < 6; i++)
        begin
            if (sfr_addr == ADDR_REG0 + 8'(i))
            begin
                sfr_sel   = 1'b1;
                sfr_rdata = md_q[i];
            end
        end
        if (sfr_addr == ADDR_CONTROL)
        begin
            sfr_sel   = 1'b1;
            sfr_rdata = {err_q, ovf_q, dir_q, cnt_q};
        end
    end

    // Sequencer, datapath and flags
    always_comb
    begin
        md_d    = md_q;
        err_d   = err_q;
        ovf_d   = ovf_q;
        dir_d   = dir_q;
        cnt_d   = cnt_q;
        ws_d    = ws_q;
        op_d    = op_q;
        busy_d  = busy_q;
        mon_d   = mon_q;
        cyc_d   = cyc_q;
        norm_d  = norm_q;
        left_d  = left_q;
        first_d = first_q;
        div32_d = div32_q;

        // Computation phase, no busy output is exported; software counts cycles
        if (busy_q)
        begin
            if (op_q == OP_SHIFT)
            begin
                if (norm_q)
                begin
                    {md_d[3], md_d[2], md_d[1], md_d[0]} = shv << step;
                    md_d[4] = md_q[4];
                    md_d[5] = md_q[5];
                    cnt_d   = cnt_q + step;
                    if (step == lz)
                    begin
                        busy_d = 1'b0;
                    end
                end
                else
                begin
                    if (dir_q)
                    begin
                        {md_d[3], md_d[2], md_d[1], md_d[0]} = shv >> step;
                    end
                    else
                    begin
                        {md_d[3], md_d[2], md_d[1], md_d[0]} = shv << step;
                    end
                    left_d = left_q - step;
                    if (left_q == step)
                    begin
                        busy_d = 1'b0;
                    end
                end
                first_d = 1'b0;
            end
            else
            begin
                cyc_d = cyc_q - 3'h1;
                if (cyc_q == 3'h1)
                begin
                    busy_d = 1'b0;
                    if (op_q == OP_MUL)
                    begin
                        {md_d[3], md_d[2], md_d[1], md_d[0]} = prod;
                        ovf_d = (prod[31:16] != 16'h0000);
                    end
                    else
                    begin
                        {md_d[3], md_d[2], md_d[1], md_d[0]} = quo32;
                        if (op_q == OP_DIV16)
                        begin
                            md_d[2] = 8'h00;
                            md_d[3] = 8'h00;
                        end
                        {md_d[5], md_d[4]} = rem16;
                        ovf_d = (dvsr == 16'h0000);
                    end
                end
            end
        end

        // Reads during a shift, or end of read-out
        if (op_q == OP_SHIFT && busy_q && (rd_md[0] || rd_md[1] || rd_md[2] || rd_md[3]))
        begin
            err_d = 1'b1;
        end
        if ((rd_md[5] && (op_q == OP_DIV32 || op_q == OP_DIV16)) ||
            (rd_md[3] && (op_q == OP_MUL || op_q == OP_SHIFT)))
        begin
            mon_d = 1'b0;
        end

        // Control read clears the error flag; a new error wins
        if (rd_ctl)
        begin
            err_d = 1'b0;
        end

        // Byte writes, tracked for order decode
        for (int i = 0; i < 6; i++)
        begin
            if (wr_md[i])
            begin
                md_d[i] = sfr_wdata;
            end
        end
        if (wr_md[0])
        begin
            if (mon_q || busy_q)
            begin
                err_d = 1'b1;
            end
            ws_d   = WS_W0;
            mon_d  = 1'b1;
            busy_d = 1'b0;
            op_d   = OP_NONE;
            div32_d = 1'b0;
        end
        else if (wr_md[1])
        begin
            ws_d = (ws_q == WS_W0) ? WS_W1 : (ws_q == WS_W04) ? WS_W041 : WS_IDLE;
        end
        else if (wr_md[2])
        begin
            ws_d = (ws_q == WS_W1) ? WS_W2 : WS_IDLE;
        end
        else if (wr_md[3])
        begin
            // Only the full 32-bit load order marks the long divide
            div32_d = (ws_q == WS_W2);
            ws_d    = (ws_q == WS_W2) ? WS_W3 : WS_IDLE;
        end
        else if (wr_md[4])
        begin
            case (ws_q)
                WS_W3:   ws_d = WS_W4;
                WS_W1:   ws_d = WS_W4;
                WS_W0:   ws_d = WS_W04;
                default: ws_d = WS_IDLE;
            endcase
        end
        else if (wr_md[5])
        begin
            // Last write starts the decoded operation
            case (ws_q)
                WS_W4:
                begin
                    // Orders 0..5 and 0,1,4,5 share this state; the flag splits them
                    op_d  = div32_q ? OP_DIV32 : OP_DIV16;
                    cyc_d = div32_q ? CYC_DIV32 : CYC_DIV16;
                end
                WS_W041:
                begin
                    op_d  = OP_MUL;
                    cyc_d = CYC_MUL;
                end
                default:
                begin
                    op_d  = OP_NONE;
                end
            endcase
            busy_d = (ws_q == WS_W4) || (ws_q == WS_W041);
            ws_d   = WS_IDLE;
        end

        // Control write launches shift or normalize
        if (wr_ctl)
        begin
            dir_d   = sfr_wdata[BIT_DIR];
            first_d = 1'b1;
            op_d    = OP_SHIFT;
            busy_d  = 1'b1;
            ws_d    = WS_IDLE;
            left_d  = sfr_wdata[4:0];
            norm_d  = (sfr_wdata[4:0] == 5'h00);
            cnt_d   = sfr_wdata[4:0];
            if (sfr_wdata[4:0] == 5'h00)
            begin
                ovf_d = md_q[3][7];
                busy_d = ~md_q[3][7];
            end
            else
            begin
                ovf_d = 1'b0;
            end
        end
    end

    // State registers
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            md_q    <= '{default: 8'h00};
            err_q   <= CONTROL_RESET[BIT_ERR];
            ovf_q   <= CONTROL_RESET[BIT_OVF];
            dir_q   <= CONTROL_RESET[BIT_DIR];
            cnt_q   <= CONTROL_RESET[4:0];
            ws_q    <= WS_IDLE;
            op_q    <= OP_NONE;
            busy_q  <= 1'b0;
            mon_q   <= 1'b0;
            cyc_q   <= 3'h0;
            norm_q  <= 1'b0;
            left_q  <= 5'h00;
            first_q <= 1'b0;
            div32_q <= 1'b0;
        end
        else
        begin
            md_q    <= md_d;
            err_q   <= err_d;
            ovf_q   <= ovf_d;
            dir_q   <= dir_d;
            cnt_q   <= cnt_d;
            ws_q    <= ws_d;
            op_q    <= op_d;
            busy_q  <= busy_d;
            mon_q   <= mon_d;
            cyc_q   <= cyc_d;
            norm_q  <= norm_d;
            left_q  <= left_d;
            first_q <= first_d;
            div32_q <= div32_d;
        end
    end

endmodule
`default_nettype wire

// ---- verif/cpu_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module cpu_model (
    // Clock
    input  wire logic       mclk,
    // Register port
    output logic      [7:0] sfr_addr,
    output logic            sfr_wr,
    output logic            sfr_rd,
    output logic      [7:0] sfr_wdata,
    input  wire logic [7:0] sfr_rdata
);
    // Quiet bus at time zero
    initial
    begin
        sfr_addr  = 8'h00;
        sfr_wr    = 1'b0;
        sfr_rd    = 1'b0;
        sfr_wdata = 8'h00;
    end
    // Strobes drop and address and data flip every cycle so a stale value never looks valid
    always @(posedge mclk)
    begin
        sfr_wr    <= 1'b0;
        sfr_rd    <= 1'b0;
        sfr_addr  <= ~sfr_addr;
        sfr_wdata <= ~sfr_wdata;
    end
    // One access: launched at the falling edge, taken at the next rising edge
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
        @(negedge mclk);
        sfr_addr  = a;
        sfr_wr    = w;
        sfr_rd    = !w;
        sfr_wdata = w ? d : ~d;
        @(posedge mclk);
        q = sfr_rdata;
    endtask
endmodule
`default_nettype wire

// ---- verif/arith_unit_asserts.sv ----
`timescale 1ns/100ps
`default_nettype none
module arith_unit_asserts
    import arith_pkg::*;
(
    // Clock and reset
    input wire logic       mclk,
    input wire logic       rst,
    // Register port
    input wire logic [7:0] sfr_addr,
    input wire logic       sfr_wr,
    input wire logic       sfr_rd,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    input wire logic       sfr_sel
);
    logic       armed_q;
    logic       armed_d;
    logic [3:0] idle_q;
    logic [3:0] idle_d;
    // Coarse monitor window; closing early on long reads only hides checks
    always_comb
    begin
        armed_d = armed_q;
        if (sfr_wr && sfr_addr == ADDR_REG0)
            armed_d = 1'b1;
        else if (sfr_rd && (sfr_addr == ADDR_REG3 || sfr_addr == ADDR_REG5))
            armed_d = 1'b0;
        idle_d = sfr_wr ? 4'h0 : idle_q + {3'h0, idle_q != 4'hF};
    end
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            armed_q <= 1'b0;
            idle_q  <= 4'h0;
        end
        else
        begin
            armed_q <= armed_d;
            idle_q  <= idle_d;
        end
    end
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);
    sequence ctrl_rd_s;
        sfr_rd && sfr_addr == ADDR_CONTROL;
    endsequence
    sequence ctrl_wr_s;
        sfr_wr && sfr_addr == ADDR_CONTROL;
    endsequence
    sequence norm_top_s;
        sfr_wr && sfr_addr == ADDR_REG3 && sfr_wdata[7] ##1 ctrl_wr_s ##0 sfr_wdata[4:0] == 5'h00;
    endsequence
    sel_decode_a: assert property (sfr_sel == (sfr_addr >= ADDR_REG0 && sfr_addr <= ADDR_CONTROL))
        else $error("select mismatch");
    unmapped_zero_a: assert property (!sfr_sel |-> sfr_rdata == 8'h00)
        else $error("unmapped read not zero");
    err_clear_a: assert property (ctrl_rd_s ##1 (sfr_addr == ADDR_CONTROL && !sfr_wr) |-> !sfr_rdata[BIT_ERR])
        else $error("error flag kept after read");
    err_set_a: assert property (armed_q && sfr_wr && sfr_addr == ADDR_REG0 ##1 ctrl_rd_s |-> sfr_rdata[BIT_ERR])
        else $error("restart not flagged");
    err_shift_a: assert property (ctrl_wr_s ##0 sfr_wdata[4:0] > 5'h0A ##1 sfr_rd && sfr_addr == ADDR_REG0 ##1 ctrl_rd_s
        |-> sfr_rdata[BIT_ERR]) else $error("read during shift not flagged");
    dir_keep_a: assert property (ctrl_wr_s ##1 sfr_addr == ADDR_CONTROL |-> sfr_rdata[BIT_DIR] == $past(sfr_wdata[BIT_DIR]))
        else $error("direction bit lost");
    norm_ovf_a: assert property (norm_top_s ##1 sfr_addr == ADDR_CONTROL |-> sfr_rdata[BIT_OVF] && sfr_rdata[4:0] == 5'h00)
        else $error("normalize overflow wrong");
    result_hold_a: assert property (idle_q > 4'h6 && $stable(sfr_addr) && !sfr_wr && sfr_addr != ADDR_CONTROL
        |-> $stable(sfr_rdata)) else $error("held result changed");
endmodule
bind arith_unit arith_unit_asserts chk_i (
    .mclk      (mclk),
    .rst       (rst),
    .sfr_addr  (sfr_addr),
    .sfr_wr    (sfr_wr),
    .sfr_rd    (sfr_rd),
    .sfr_wdata (sfr_wdata),
    .sfr_rdata (sfr_rdata),
    .sfr_sel   (sfr_sel)
);
`default_nettype wire

// ---- verif/test_mul_div_shift_unit.sv ----
`timescale 1ns/100ps
`default_nettype none
module test_mul_div_shift_unit
    import arith_pkg::*;
;
    logic       mclk;
    logic       rst;
    logic [7:0] sfr_addr;
    logic       sfr_wr;
    logic       sfr_rd;
    logic [7:0] sfr_wdata;
    logic [7:0] sfr_rdata;
    logic       sfr_sel;
    int         failures;
    int         tests_run;
    // 50 MHz machine clock
    initial mclk = 1'b0;
    always #10 mclk = ~mclk;
    arith_unit uut (
        .mclk      (mclk),
        .rst       (rst),
        .sfr_addr  (sfr_addr),
        .sfr_wr    (sfr_wr),
        .sfr_rd    (sfr_rd),
        .sfr_wdata (sfr_wdata),
        .sfr_rdata (sfr_rdata),
        .sfr_sel   (sfr_sel)
    );
    cpu_model cpu (
        .mclk      (mclk),
        .sfr_addr  (sfr_addr),
        .sfr_wr    (sfr_wr),
        .sfr_rd    (sfr_rd),
        .sfr_wdata (sfr_wdata),
        .sfr_rdata (sfr_rdata)
    );
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        cpu.acc(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] q);
        cpu.acc(1'b0, a, 8'h00, q);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            failures++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Word in registers 0..3, low byte first, register 3 last
    task automatic ld(input logic [31:0] v);
        for (int i = 0; i < 4; i++)
            wr(ADDR_REG0 + 8'(i), v[8*i +: 8]);
    endtask
    task automatic rd32(output logic [31:0] v);
        for (int i = 0; i < 4; i++)
            rd(ADDR_REG0 + 8'(i), v[8*i +: 8]);
    endtask
    task automatic t_reset;
        logic [7:0] q;
        rd(ADDR_REG5, q);
        chk(q, 8'h00);
        rd(ADDR_REG5, q);
        chk(q, 8'h00);
        rd(ADDR_CONTROL, q);
        chk(q, CONTROL_RESET);
        rd(8'h10, q);
        chk(q, 8'h00);
    endtask
    task automatic t_mul(input logic [15:0] a, input logic [15:0] b);
        logic [31:0] r;
        logic [7:0]  c;
        wr(ADDR_REG0, a[7:0]);
        wr(ADDR_REG4, b[7:0]);
        wr(ADDR_REG1, a[15:8]);
        wr(ADDR_REG5, b[15:8]);
        repeat (CYC_MUL) @(posedge mclk);
        rd(ADDR_CONTROL, c);
        chk(c[7:6], {1'b0, (a * b > 32'h0000FFFF)});
        rd32(r);
        chk(r, a * b);
    endtask
    // Big selects the 32-bit dividend order 0..5, else 0,1,4,5
    task automatic t_div(input logic [31:0] a, input logic [15:0] b, input logic big);
        logic [31:0] q;
        logic [15:0] r;
        logic [7:0]  c;
        for (int i = 0; i < (big ? 4 : 2); i++)
            wr(ADDR_REG0 + 8'(i), a[8*i +: 8]);
        wr(ADDR_REG4, b[7:0]);
        wr(ADDR_REG5, b[15:8]);
        repeat (big ? CYC_DIV32 : CYC_DIV16) @(posedge mclk);
        rd32(q);
        rd(ADDR_REG4, r[7:0]);
        rd(ADDR_REG5, r[15:8]);
        rd(ADDR_CONTROL, c);
        chk(q, b != 16'h0000 ? a / b : 32'hFFFFFFFF);
        chk(r, b != 16'h0000 ? a % b : 32'h0000FFFF);
        chk(c[7:6], {1'b0, (b == 16'h0000)});
    endtask
    task automatic t_shift(input logic [31:0] v, input logic [7:0] ctl);
        logic [31:0] e;
        logic [31:0] r;
        logic [7:0]  c;
        logic [4:0]  n;
        e = ctl[5] ? v >> ctl[4:0] : v << ctl[4:0];
        n = 5'h00;
        while (ctl[4:0] == 5'h00 && !e[31] && n != 5'h1F)
        begin
            e = e << 1;
            n++;
        end
        ld(v);
        wr(ADDR_CONTROL, ctl);
        rd(ADDR_CONTROL, c);
        repeat (6) @(posedge mclk);
        rd(ADDR_CONTROL, c);
        chk(c[7:5], {1'b0, (ctl[4:0] == 5'h00 && v[31]), ctl[5]});
        if (ctl[4:0] == 5'h00)
            chk(c[4:0], n);
        else
            chk(c[4:0], ctl[4:0]);
        rd32(r);
        chk(r, e);
    endtask
    // Restart mid-load, then a result read mid-shift
    task automatic t_err;
        logic [7:0]  c;
        logic [31:0] r;
        wr(ADDR_REG0, 8'h11);
        wr(ADDR_REG1, 8'h22);
        wr(ADDR_REG0, 8'h33);
        rd(ADDR_CONTROL, c);
        chk(c[7], 1'b1);
        rd(ADDR_CONTROL, c);
        chk(c[7], 1'b0);
        t_shift(32'h0000F00D, 8'h04);
        ld(32'h00000001);
        wr(ADDR_CONTROL, 8'h1F);
        rd(ADDR_REG0, c);
        rd(ADDR_CONTROL, c);
        chk(c[7], 1'b1);
        repeat (6) @(posedge mclk);
        rd32(r);
        chk(r, 32'h80000000);
    endtask
    task automatic conclude;
        if (failures == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // Whole run needs a few hundred cycles
    initial
    begin
        repeat (5000) @(posedge mclk);
        failures++;
        conclude;
    end
    initial
    begin
        failures  = 0;
        tests_run = 0;
        rst       = 1'b1;
        repeat (10) @(posedge mclk);
        @(negedge mclk);
        rst = 1'b0;
        repeat (8) @(posedge mclk);
        t_reset;
        t_mul(16'h1234, 16'h5678);
        t_mul(16'h0003, 16'h0005);
        t_div(32'h12345678, 16'h1234, 1'b1);
        t_div(32'h0000BEEF, 16'h0123, 1'b0);
        t_div(32'h00010042, 16'h0000, 1'b1);
        t_shift(32'h12345678, 8'h45);
        t_shift(32'h80000001, 8'h3F);
        t_shift(32'h00001234, 8'h00);
        t_shift(32'h80000000, 8'h00);
        t_err;
        conclude;
    end
endmodule
`default_nettype wire
